// File: design/tli_unit.sv
// Contract
// - signed forms treat entries as two's-complement of 8, 16 or 32 bits
// - adjust bit 0 gives rounded result, 1 gives unrounded with fraction
// - signed rounding adds -1, 0 or +1 by difference fraction vs one half
// - rounded result writes only the low size bits of the destination
// - unrounded integer goes to bits 15:8, 23:8 or 31:8 by size
// - signed unrounded byte and word results are sign-extended to 32 bits
// - unrounded results return the 8-bit fraction in bits 7:0
// - X kept, N from result msb, Z on zero result, C always cleared
// - signed V set only when unrounded long integer exceeds 24 signed bits
// - extension word gives destination, signedness, adjust bit and form
// - size field 00 byte, 01 word, 10 long
// - table base accepts only control operand modes
// - mode zero means register interpolation; mode and form bit must agree, else the encoding is refused
// - rounded is entry plus scaled difference over 256; unrounded times 256
// - table mode fetches entry at base plus scaled integer, and the next
// - register mode uses both operand registers and only the fraction byte
// - destination low word is 8-bit integer and 8-bit fraction
// - unsigned forms take entries unsigned and zero-extend unrounded results
// - unsigned rounding adds 1 when the fraction is at least one half
`timescale 1ns/1ps
module tli_unit (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // decoded instruction from the sequencer
    input wire logic OP_VALID,
    output logic OP_READY,
    input wire logic [15:0] OP_WORD,
    input wire logic [15:0] OP_EXT,
    input wire logic [31:0] DEST_VAL,
    input wire logic [31:0] REG_M_VAL,
    input wire logic [31:0] REG_N_VAL,
    input wire logic [31:0] EA_ADDR,
    input wire logic [4:0] CCR_IN,
    // table read port
    output logic MEM_REQ,
    output logic [31:0] MEM_ADDR,
    output logic [1:0] MEM_SIZE,
    input wire logic MEM_ACK,
    input wire logic [31:0] MEM_RDATA,
    // result
    output logic WB_VALID,
    output logic [2:0] WB_IDX,
    output logic [31:0] WB_DATA,
    output logic [4:0] CCR_OUT,
    output logic ILLEGAL
);
    tli_pkg::tli_state_t state_ff;
    logic [15:0] ext_ff;
    logic [31:0] dest_ff, a_ff, b_ff, mem_addr_ff, res_ff, prdata_ff;
    logic x_ff, mem_req_ff, done_ff, ill_ff, ctrl_en_ff, st_ill_ff;
    logic [4:0] ccr_ff;
    logic [2:0] in_mode, in_reg;
    logic [1:0] in_size, size;
    logic in_form, ctl_ok, in_legal, accept, sgn, nadj;
    logic [31:0] first_addr, step;
    logic signed [32:0] a_x, b_x;
    logic signed [33:0] diff;
    logic signed [42:0] prod, unr, pabs, rsum;
    logic [34:0] qmag;
    logic [32:0] delta, rnd;
    logic [31:0] res;
    logic n_f, z_f, v_f, e_bit;
    logic apb_wr, apb_rd_setup, hit;

    // decode of the offered instruction
    assign in_mode = OP_WORD[tli_pkg::OF_MODE_HI:tli_pkg::OF_MODE_LO];
    assign in_reg = OP_WORD[tli_pkg::OF_REG_HI:tli_pkg::OF_REG_LO];
    assign in_form = OP_EXT[tli_pkg::XF_FORM];
    assign in_size = OP_EXT[tli_pkg::XF_SIZE_HI:tli_pkg::XF_SIZE_LO];
    // control modes only; absolute and pc-relative share mode 111
    assign ctl_ok = (in_mode == tli_pkg::MD_IND) || (in_mode == tli_pkg::MD_DISP)
        || (in_mode == tli_pkg::MD_IDX)
        || (in_mode == tli_pkg::MD_ABS && in_reg <= tli_pkg::ABS_REG_MAX);
    // form bit and mode field must agree, else the encoding is refused
    assign in_legal = (in_size != 2'h3)
        && (in_form ? ctl_ok : (in_mode == tli_pkg::MD_REG));
    assign OP_READY = CE && ctrl_en_ff && (state_ff == tli_pkg::S_IDLE);
    assign accept = OP_VALID && OP_READY;
    // entry offset: integer byte scaled by size
    assign first_addr = EA_ADDR
        + ({24'h000000, DEST_VAL[tli_pkg::DX_INT_HI:tli_pkg::DX_INT_LO]} << in_size);

    assign sgn = ext_ff[tli_pkg::XF_SIGNED];
    assign nadj = ext_ff[tli_pkg::XF_NADJ];
    assign size = ext_ff[tli_pkg::XF_SIZE_HI:tli_pkg::XF_SIZE_LO];
    assign step = 32'h00000001 << size;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= tli_pkg::S_IDLE;
        end else if (CE) begin
            unique case (state_ff)
                tli_pkg::S_IDLE: begin
                    if (accept && in_legal) begin
                        state_ff <= in_form ? tli_pkg::S_FETCH0 : tli_pkg::S_CALC;
                    end
                end
                tli_pkg::S_FETCH0: begin
                    if (MEM_ACK) begin
                        state_ff <= tli_pkg::S_FETCH1;
                    end
                end
                tli_pkg::S_FETCH1: begin
                    if (MEM_ACK) begin
                        state_ff <= tli_pkg::S_CALC;
                    end
                end
                tli_pkg::S_CALC: begin
                    state_ff <= tli_pkg::S_IDLE;
                end
            endcase
        end
    end

    // operand capture; register mode takes both entries from the registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_ff <= 16'h0000;
            dest_ff <= 32'h00000000;
            a_ff <= 32'h00000000;
            b_ff <= 32'h00000000;
            x_ff <= 1'b0;
        end else if (CE) begin
            if (accept && in_legal) begin
                ext_ff <= OP_EXT;
                dest_ff <= DEST_VAL;
                x_ff <= CCR_IN[tli_pkg::CC_X];
                a_ff <= REG_M_VAL;
                b_ff <= REG_N_VAL;
            end else if (state_ff == tli_pkg::S_FETCH0 && MEM_ACK) begin
                a_ff <= MEM_RDATA;
            end else if (state_ff == tli_pkg::S_FETCH1 && MEM_ACK) begin
                b_ff <= MEM_RDATA;
            end
        end
    end

    // two reads, entry n then entry n+1 one size further on
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mem_req_ff <= 1'b0;
            mem_addr_ff <= 32'h00000000;
        end else if (CE) begin
            if (accept && in_legal && in_form) begin
                mem_req_ff <= 1'b1;
                mem_addr_ff <= first_addr;
            end else if (state_ff == tli_pkg::S_FETCH0 && MEM_ACK) begin
                mem_addr_ff <= mem_addr_ff + step;
            end else if (state_ff == tli_pkg::S_FETCH1 && MEM_ACK) begin
                mem_req_ff <= 1'b0;
            end
        end
    end
    assign MEM_REQ = mem_req_ff;
    assign MEM_ADDR = mem_addr_ff;
    assign MEM_SIZE = size;

    function automatic logic [32:0] widen(input logic [31:0] v, input logic [1:0] sz,
                                          input logic sg);
        logic [32:0] w;
        w = {sg & v[31], v};
        if (sz == tli_pkg::SZ_BYTE) begin
            w = {{25{sg & v[7]}}, v[7:0]};
        end else if (sz == tli_pkg::SZ_WORD) begin
            w = {{17{sg & v[15]}}, v[15:0]};
        end
        return w;
    endfunction

    // two extra bits keep the entry difference exact for 32-bit entries
    always_comb begin
        a_x = widen(a_ff, size, sgn);
        b_x = widen(b_ff, size, sgn);
        diff = {b_x[32], b_x} - {a_x[32], a_x};
        // fraction byte only; bits 15:8 never enter the arithmetic
        prod = diff * $signed({1'b0, dest_ff[tli_pkg::DX_FRAC_HI:0]});
        unr = {{2{a_x[32]}}, a_x, 8'h00} + prod;
        pabs = prod[42] ? -prod : prod;
        qmag = pabs[42:8] + {34'h000000000, pabs[7]};
        rsum = prod + {35'h000000000, tli_pkg::HALF};
        if (sgn) begin
            // magnitude rounding: symmetric about zero
            delta = prod[42] ? (~qmag[32:0] + 33'h000000001) : qmag[32:0];
        end else begin
            delta = rsum[40:8];
        end
        rnd = a_x + delta;
        res = rnd[31:0];
        e_bit = 1'b0;
        n_f = res[31];
        z_f = (res == 32'h00000000);
        if (!nadj) begin
            unique case (size)
                tli_pkg::SZ_BYTE: begin
                    res = {dest_ff[31:8], rnd[7:0]};
                    n_f = rnd[7];
                    z_f = (rnd[7:0] == 8'h00);
                end
                tli_pkg::SZ_WORD: begin
                    res = {dest_ff[31:16], rnd[15:0]};
                    n_f = rnd[15];
                    z_f = (rnd[15:0] == 16'h0000);
                end
                default: begin
                    res = rnd[31:0];
                    n_f = rnd[31];
                    z_f = (rnd[31:0] == 32'h00000000);
                end
            endcase
        end else begin
            unique case (size)
                tli_pkg::SZ_BYTE: begin
                    e_bit = sgn & unr[15];
                    res = {{16{e_bit}}, unr[15:0]};
                end
                tli_pkg::SZ_WORD: begin
                    e_bit = sgn & unr[23];
                    res = {{8{e_bit}}, unr[23:0]};
                end
                default: begin
                    res = unr[31:0];
                end
            endcase
            n_f = res[31];
            z_f = (res == 32'h00000000);
        end
        // long unrounded keeps only 24 integer bits; V flags what was lost
        v_f = 1'b0;
        if (nadj && size == tli_pkg::SZ_LONG) begin
            v_f = sgn ? !((&unr[42:31]) || !(|unr[42:31])) : (|unr[42:32]);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_ff <= 1'b0;
            ill_ff <= 1'b0;
            res_ff <= 32'h00000000;
            ccr_ff <= 5'h00;
        end else if (CE) begin
            done_ff <= (state_ff == tli_pkg::S_CALC);
            ill_ff <= accept && !in_legal;
            if (state_ff == tli_pkg::S_CALC) begin
                res_ff <= res;
                ccr_ff <= {x_ff, n_f, z_f, v_f, 1'b0};
            end
        end
    end
    assign WB_VALID = done_ff;
    assign WB_DATA = res_ff;
    assign WB_IDX = ext_ff[tli_pkg::XF_DEST_HI:tli_pkg::XF_DEST_LO];
    assign CCR_OUT = ccr_ff;
    assign ILLEGAL = ill_ff;

    // apb: zero wait states, read data latched in the setup cycle
    assign PREADY = CE;
    assign hit = (PADDR == tli_pkg::A_CTRL) || (PADDR == tli_pkg::A_STAT)
        || (PADDR == tli_pkg::A_RES);
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign apb_wr = PSEL && PENABLE && PWRITE && CE;
    assign apb_rd_setup = PSEL && !PENABLE && !PWRITE;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_en_ff <= tli_pkg::CTRL_EN_RST;
        end else if (apb_wr && PADDR == tli_pkg::A_CTRL && PSTRB[0]) begin
            ctrl_en_ff <= PWDATA[0];
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ill_ff <= 1'b0;
        end else if (CE) begin
            if (accept && !in_legal) begin
                st_ill_ff <= 1'b1;
            end else if (apb_wr && PADDR == tli_pkg::A_STAT && PSTRB[0]
                         && PWDATA[tli_pkg::ST_ILL]) begin
                st_ill_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_ff <= 32'h00000000;
        end else if (CE && apb_rd_setup) begin
            prdata_ff <= 32'h00000000;
            if (PADDR == tli_pkg::A_CTRL) begin
                prdata_ff[0] <= ctrl_en_ff;
            end else if (PADDR == tli_pkg::A_STAT) begin
                prdata_ff[tli_pkg::ST_BUSY] <= (state_ff != tli_pkg::S_IDLE);
                prdata_ff[tli_pkg::ST_ILL] <= st_ill_ff;
                prdata_ff[tli_pkg::ST_CC_HI:tli_pkg::ST_CC_LO] <= ccr_ff;
            end else if (PADDR == tli_pkg::A_RES) begin
                prdata_ff <= res_ff;
            end
        end
    end
    assign PRDATA = prdata_ff;

    // checks; a frozen clock enable aborts attempts in flight
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !CE);

    illegal_no_write_a: assert property (accept && !in_legal |=> ILLEGAL ##1 !WB_VALID)
        else $error("illegal op not flagged or still written");
    carry_clear_a: assert property (WB_VALID |-> !CCR_OUT[tli_pkg::CC_C]
        && CCR_OUT[tli_pkg::CC_X] == x_ff)
        else $error("carry set or extend changed");
    zero_flag_a: assert property (WB_VALID && nadj
        |-> CCR_OUT[tli_pkg::CC_Z] == (WB_DATA == 32'h00000000))
        else $error("zero flag disagrees with result");
    rounded_keep_a: assert property (WB_VALID && !nadj && size == tli_pkg::SZ_BYTE
        |-> WB_DATA[31:8] == dest_ff[31:8])
        else $error("rounded byte disturbed upper bits");
    sign_extend_a: assert property (WB_VALID && nadj && sgn && size == tli_pkg::SZ_BYTE
        |-> WB_DATA[31:16] == {16{WB_DATA[15]}})
        else $error("unrounded byte not sign-extended");
    zero_extend_a: assert property (WB_VALID && nadj && !sgn && size == tli_pkg::SZ_WORD
        |-> WB_DATA[31:24] == 8'h00)
        else $error("unsigned word not zero-extended");
    overflow_only_a: assert property (WB_VALID && !(nadj && size == tli_pkg::SZ_LONG)
        |-> !CCR_OUT[tli_pkg::CC_V])
        else $error("overflow outside unrounded long");
    fetch_addr_a: assert property (accept && in_legal && in_form
        |=> MEM_REQ && MEM_ADDR == $past(first_addr))
        else $error("first table address wrong");
    reg_mode_a: assert property (accept && in_legal && !in_form
        |-> !MEM_REQ [*3] ##0 WB_VALID)
        else $error("register mode fetched or late");

    table_done_c: cover property (accept && in_legal && in_form ##[4:40] WB_VALID);
    reg_done_c: cover property (accept && in_legal && !in_form ##2 WB_VALID);
    illegal_c: cover property (ILLEGAL);
    long_ovf_c: cover property (WB_VALID && CCR_OUT[tli_pkg::CC_V]);
endmodule

// File: design/tli_pkg.sv
package tli_pkg;
    // extension word fields
    localparam int XF_DEST_HI = 14;
    localparam int XF_DEST_LO = 12;
    localparam int XF_SIGNED = 11;
    localparam int XF_NADJ = 10;
    localparam int XF_FORM = 8;
    localparam int XF_SIZE_HI = 7;
    localparam int XF_SIZE_LO = 6;
    // first opcode word fields
    localparam int OF_MODE_HI = 5;
    localparam int OF_MODE_LO = 3;
    localparam int OF_REG_HI = 2;
    localparam int OF_REG_LO = 0;
    // destination low word: integer part above the binary point
    localparam int DX_INT_HI = 15;
    localparam int DX_INT_LO = 8;
    localparam int DX_FRAC_HI = 7;
    // condition code positions
    localparam int CC_X = 4;
    localparam int CC_N = 3;
    localparam int CC_Z = 2;
    localparam int CC_V = 1;
    localparam int CC_C = 0;
    // operation sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // operand modes
    localparam logic [2:0] MD_REG = 3'h0;
    localparam logic [2:0] MD_IND = 3'h2;
    localparam logic [2:0] MD_DISP = 3'h5;
    localparam logic [2:0] MD_IDX = 3'h6;
    localparam logic [2:0] MD_ABS = 3'h7;
    localparam logic [2:0] ABS_REG_MAX = 3'h3;
    // one half of an interpolation step
    localparam logic [7:0] HALF = 8'h80;
    // register map
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_RES = 12'h008;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_BUSY = 0;
    localparam int ST_ILL = 1;
    localparam int ST_CC_LO = 2;
    localparam int ST_CC_HI = 6;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_FETCH0 = 2'b01,
        S_FETCH1 = 2'b10,
        S_CALC = 2'b11
    } tli_state_t;
endpackage

// File: sim/tli_mem_model.sv
`timescale 1ns/1ps
// table memory behind the read port; answers after lat idle cycles
module tli_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // read port
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [1:0] size,
    input wire logic [3:0] lat,
    output logic ack,
    output logic [31:0] rdata
);
    logic [7:0] mem [256];
    logic [31:0] adr_log [2];
    logic n_rd_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [3:0] wait_ff;
    logic [7:0] a;
    assign a = addr[7:0];
    assign ack = ack_ff;
    assign rdata = rdata_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'h0;
            rdata_ff <= 32'h0;
            wait_ff <= 4'h0;
            n_rd_ff <= 1'h0;
        end else begin
            ack_ff <= 1'h0;
            // data is not held past the ack cycle
            rdata_ff <= ~rdata_ff;
            if (req && !ack_ff && wait_ff < lat) begin
                wait_ff <= wait_ff + 4'h1;
            end else if (req && !ack_ff) begin
                ack_ff <= 1'h1;
                wait_ff <= 4'h0;
                adr_log[n_rd_ff] <= addr;
                n_rd_ff <= ~n_rd_ff;
                case (size)
                    2'h0: rdata_ff <= {24'h0, mem[a]};
                    2'h1: rdata_ff <= {16'h0, mem[a], mem[a + 8'h1]};
                    default: rdata_ff <= {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]};
                endcase
            end
        end
    end
endmodule

// File: sim/table_lookup_interpolate_unit_tb_top.sv
`timescale 1ns/1ps
module table_lookup_interpolate_unit_tb_top;
    typedef struct packed {
        logic [15:0] ext;
        logic [31:0] dest;
        logic [31:0] m;
        logic [31:0] n;
        logic [31:0] wb;
        logic [4:0] cc;
    } tli_row_t;
    logic CLK = 1'h0, RST_N = 1'h0, CE = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic [11:0] PADDR = 12'h0;
    logic [3:0] PSTRB = 4'hF;
    logic [31:0] PWDATA = 32'h0, DEST_VAL = 32'h0, REG_M_VAL = 32'h0, REG_N_VAL = 32'h0;
    logic [31:0] EA_ADDR = 32'h0;
    logic OP_VALID = 1'h0;
    logic [15:0] OP_WORD = 16'h0, OP_EXT = 16'h0;
    logic [4:0] CCR_IN = 5'h0;
    logic PREADY, PSLVERR, OP_READY, MEM_REQ, MEM_ACK, WB_VALID, ILLEGAL;
    logic [31:0] PRDATA, MEM_ADDR, MEM_RDATA, WB_DATA;
    logic [4:0] CCR_OUT;
    logic [2:0] WB_IDX;
    logic [1:0] MEM_SIZE;
    logic [31:0] rd_s, wb_s, cyc_s;
    logic [4:0] cc_s;
    logic [2:0] idx_s;
    logic er_s, ill_s;
    logic [3:0] lat_s = 4'h0;
    int err_total = 0;
    int n_checks = 0;
    // ext, dest, first entry, second entry, result, flags X N Z V C
    tli_row_t tv [14] = '{
        '{16'h1800, 32'h12345680, 32'h10, 32'h20, 32'h12345618, 5'h10},
        '{16'h1800, 32'hAABBCC80, 32'h77777700, 32'hFF, 32'hAABBCCFF, 5'h08},
        '{16'h2840, 32'h5555AA7F, 32'h100, 32'hABCD00FF, 32'h55550100, 5'h10},
        '{16'h3C00, 32'h9940, 32'hFE, 32'h2, 32'hFFFFFF00, 5'h08},
        '{16'h3400, 32'h9940, 32'hFE, 32'h2, 32'hBF00, 5'h10},
        '{16'h4C80, 32'h0, 32'h800000, 32'h800000, 32'h80000000, 5'h0A},
        '{16'h4C80, 32'h1200, 32'h7FFFFF, 32'h7FFFFF, 32'h7FFFFF00, 5'h10},
        '{16'h5080, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 5'h04},
        '{16'h6040, 32'h11112280, 32'h0, 32'h1, 32'h11110001, 5'h10},
        '{16'h7000, 32'h1111227F, 32'h0, 32'h1, 32'h11112200, 5'h04},
        '{16'h0C40, 32'h10, 32'h8000, 32'h8000, 32'hFF800000, 5'h18},
        '{16'h0440, 32'h10, 32'h8000, 32'h8000, 32'h800000, 5'h00},
        '{16'h0480, 32'h0, 32'h1000000, 32'h1000000, 32'h0, 5'h16},
        '{16'h1840, 32'h5A5A0080, 32'h10, 32'h11, 32'h5A5A0011, 5'h10}
    };
    // opcode word and extension word of refused instructions
    logic [31:0] bad [5] = '{32'h08C0, 32'h180900, 32'h3C0900, 32'h80800, 32'h0900};

    tli_unit i_dut (
        .CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
        .PREADY, .PSLVERR, .OP_VALID, .OP_READY, .OP_WORD, .OP_EXT, .DEST_VAL, .REG_M_VAL,
        .REG_N_VAL, .EA_ADDR, .CCR_IN, .MEM_REQ, .MEM_ADDR, .MEM_SIZE, .MEM_ACK, .MEM_RDATA,
        .WB_VALID, .WB_IDX, .WB_DATA, .CCR_OUT, .ILLEGAL
    );
    tli_mem_model i_mem (
        .clk(CLK), .rst_n(RST_N), .req(MEM_REQ), .addr(MEM_ADDR), .size(MEM_SIZE),
        .lat(lat_s), .ack(MEM_ACK), .rdata(MEM_RDATA)
    );

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        k = 0;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'h1 && k < 20);
        if (PREADY !== 1'h1) begin
            err_total++;
            wrap_up();
        end
        rd_s = PRDATA;
        er_s = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    // offers one instruction, then waits for its write-back or refusal
    task automatic op(input logic [15:0] w, e, input logic [31:0] d, m, n, ea, input logic x);
        @(posedge CLK);
        OP_VALID <= 1'h1;
        OP_WORD <= w;
        OP_EXT <= e;
        DEST_VAL <= d;
        REG_M_VAL <= m;
        REG_N_VAL <= n;
        EA_ADDR <= ea;
        CCR_IN <= {x, 4'hF};
        cyc_s = 32'h0;
        do begin
            @(negedge CLK);
            cyc_s++;
        end while (OP_READY !== 1'h1 && cyc_s < 32'h32);
        @(posedge CLK);
        OP_VALID <= 1'h0;
        cyc_s = 32'h0;
        do begin
            @(negedge CLK);
            cyc_s++;
        end while (WB_VALID !== 1'h1 && ILLEGAL !== 1'h1 && cyc_s < 32'h3C);
        if (WB_VALID !== 1'h1 && ILLEGAL !== 1'h1) begin
            err_total++;
            wrap_up();
        end
        ill_s = ILLEGAL;
        wb_s = WB_DATA;
        cc_s = CCR_OUT;
        idx_s = WB_IDX;
    endtask

    initial begin
        forever #5 CLK = ~CLK;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'h1;
        {i_mem.mem[8'h16], i_mem.mem[8'h17], i_mem.mem[8'h18], i_mem.mem[8'h19]} = 32'hFF000100;
        {i_mem.mem[8'h24], i_mem.mem[8'h25], i_mem.mem[8'h26], i_mem.mem[8'h27]} = 32'h10;
        {i_mem.mem[8'h28], i_mem.mem[8'h29], i_mem.mem[8'h2A], i_mem.mem[8'h2B]} = 32'h30;
        @(negedge CLK);
        chk("reset_outputs", 32'h4, {29'h0, OP_READY, WB_VALID, MEM_REQ});
        apb(1'h0, tli_pkg::A_CTRL, 32'h0);
        chk("ctrl_reset", 32'h1, {31'h0, rd_s[0]});
        apb(1'h0, 12'h00C, 32'h0);
        chk("unmapped", 32'h1, {rd_s[30:0], er_s});
        for (int i = 0; i < 14; i++) begin
            op(16'h3, tv[i].ext, tv[i].dest, tv[i].m, tv[i].n, 32'h0, tv[i].cc[4]);
            chk("wb_data", tv[i].wb, wb_s);
            // result must stand after the one-cycle valid pulse has gone
            @(negedge CLK);
            chk("wb_again", tv[i].wb, WB_DATA);
            chk("wb_pulse", 32'h0, {31'h0, WB_VALID});
            chk("ccr", {27'h0, tv[i].cc}, {27'h0, cc_s});
            chk("dest_idx", {29'h0, tv[i].ext[14:12]}, {29'h0, idx_s});
            chk("latency", 32'h2, cyc_s);
        end
        apb(1'h0, tli_pkg::A_RES, 32'h0);
        chk("result_reg", tv[13].wb, rd_s);
        apb(1'h0, tli_pkg::A_STAT, 32'h0);
        chk("status_ccr", {27'h0, tv[13].cc}, {27'h0, rd_s[tli_pkg::ST_CC_HI:tli_pkg::ST_CC_LO]});
        // clock enable low must hold off both handshakes
        CE <= 1'h0;
        @(negedge CLK);
        chk("ce_freeze", 32'h0, {30'h0, OP_READY, PREADY});
        @(posedge CLK);
        CE <= 1'h1;
        lat_s <= 4'h3;
        // small index keeps the table well inside its length; unused operand field zero
        op(16'h10, 16'h1940, 32'h340, 32'hDEADBEEF, 32'hDEADBEEF, 32'h10, 1'h0);
        chk("tbl_word", 32'hFF80, wb_s);
        chk("tbl_word_ccr", 32'h08, {27'h0, cc_s});
        chk("tbl_addr0", 32'h16, i_mem.adr_log[0]);
        chk("tbl_addr1", 32'h18, i_mem.adr_log[1]);
        @(posedge CLK);
        lat_s <= 4'h0;
        op(16'h39, 16'h2580, 32'h180, 32'hDEADBEEF, 32'hDEADBEEF, 32'h20, 1'h1);
        chk("tbl_long", 32'h2000, wb_s);
        chk("tbl_long_a0", 32'h24, i_mem.adr_log[0]);
        chk("tbl_long_a1", 32'h28, i_mem.adr_log[1]);
        apb(1'h0, tli_pkg::A_RES, 32'h0);
        chk("result_long", 32'h2000, rd_s);
        for (int i = 0; i < 5; i++) begin
            op(bad[i][31:16], bad[i][15:0], 32'h0, 32'h0, 32'h0, 32'h40, 1'h0);
            chk("illegal", 32'h1, {31'h0, ill_s});
            chk("illegal_lat", 32'h1, cyc_s);
            repeat (3) begin
                @(negedge CLK);
                chk("no_write", 32'h0, {30'h0, WB_VALID, MEM_REQ});
            end
        end
        apb(1'h0, tli_pkg::A_STAT, 32'h0);
        chk("ill_seen", 32'h1, {31'h0, rd_s[tli_pkg::ST_ILL]});
        apb(1'h1, tli_pkg::A_STAT, 32'h1 << tli_pkg::ST_ILL);
        apb(1'h0, tli_pkg::A_STAT, 32'h0);
        chk("ill_cleared", 32'h0, {31'h0, rd_s[tli_pkg::ST_ILL]});
        apb(1'h1, tli_pkg::A_CTRL, 32'h0);
        @(negedge CLK);
        chk("ready_off", 32'h0, {31'h0, OP_READY});
        @(posedge CLK);
        RST_N <= 1'h0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'h1;
        apb(1'h0, tli_pkg::A_CTRL, 32'h0);
        chk("ctrl_rereset", 32'h1, {31'h0, rd_s[0]});
        wrap_up();
    end
endmodule
